// *** core/sdi_tx_map.svh ***
`ifndef SDI_TX_MAP_SVH
`define SDI_TX_MAP_SVH

// Timing reference words and blanking levels
`define TRS_ONES 10'h3ff
`define TRS_ZERO 10'h000
`define BLANK_Y 10'h040
`define BLANK_C 10'h200

// Word positions counted from the first word of a timing reference
`define POS_XYZ 5'h03
`define POS_LN0 5'h04
`define POS_LN1 5'h05
`define POS_CR0 5'h06
`define POS_CR1 5'h07
`define SLOT_HD 5'h08
`define SLOT_SD 5'h04
`define POS_MAX 5'h1f

// Packet layout
`define DID_VPID 8'h41
`define SDID_VPID 8'h01
`define DID_EDH 8'hf4
`define DBN_EDH 8'h01
`define VPID_LEN 8'h04
`define EDH_LEN 8'h02
`define LAST_VPID 4'ha
`define LAST_EDH 4'h8
`define PKT_CS0 4'h3

// Line CRC, reflected form of x^18 + x^5 + x^4 + 1
`define CRC_POLY 18'h23000

// Register offsets and control fields
`define REG_CTRL 12'h000
`define REG_STAT 12'h004
`define CTRL_RST 32'h0000_0000
`define CTRL_CRC 0
`define CTRL_LN 1
`define CTRL_EDH 2
`define CTRL_VPID 3
`define CTRL_OVW 4
`define CTRL_LVLB 5
`define CTRL_MODE 8
`define CTRL_RUN 16
`define CTRL_MASK 32'h0001_033f
`define XYZ_POS 4'h3

`endif

// *** core/sdi_tx_pkg.sv ***
package sdi_tx_pkg;

    typedef logic [9:0] word_type;

    typedef enum logic [1:0] {
        MODE_HD = 2'b00,
        MODE_SD = 2'b01,
        MODE_3G = 2'b10,
        MODE_BAD = 2'b11
    } mode_type;

    typedef enum logic {
        PKT_IDLE = 1'b0,
        PKT_SEND = 1'b1
    } pkt_state_type;

    typedef enum logic [1:0] {
        PH_EAV = 2'b00,
        PH_HBLK = 2'b01,
        PH_SAV = 2'b10,
        PH_ACT = 2'b11
    } phase_type;

    typedef struct packed {
        word_type [3:0] yd;
        word_type [3:0] cd;
        logic [4:0] pos;
        logic eav;
        logic hd;
        logic sd;
        logic ins_ln;
        logic ins_edh;
        logic ins_vpid;
        logic ovw;
        logic fld;
        logic edh_pend;
        logic vpid_pend;
        pkt_state_type pst;
        logic kind_edh;
        logic [3:0] idx;
        logic [3:0] last;
        logic [8:0] cs;
        logic [31:0] udw;
        logic [15:0] sum;
        logic crc_on;
        logic crc_rdy;
        logic [17:0] crc_y;
        logic [17:0] crc_c;
        logic [10:0] ln;
        word_type y_out;
        word_type c_out;
    } tx_state_type;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rdata;
        phase_type ph;
        logic [11:0] wcnt;
        logic [10:0] line;
        logic fld;
        word_type y;
        word_type c;
    } src_state_type;

endpackage

// *** core/sdi_tx_if.sv ***
`timescale 1ns/10ps
interface sdi_tx_if;
    import sdi_tx_pkg::*;

    word_type video_a_y;
    word_type video_a_c;
    mode_type mode;
    logic high_rate_level_select;
    logic insert_crc;
    logic insert_ln;
    logic insert_edh;
    logic insert_vpid;
    logic overwrite_vpid;
    logic [10:0] line_a;
    logic [10:0] line_b;

    modport source (
        output video_a_y, video_a_c, mode, high_rate_level_select,
        output insert_crc, insert_ln, insert_edh, insert_vpid, overwrite_vpid,
        output line_a, line_b
    );

    modport transmitter (
        input video_a_y, video_a_c, mode, high_rate_level_select,
        input insert_crc, insert_ln, insert_edh, insert_vpid, overwrite_vpid,
        input line_a, line_b
    );
endinterface

// *** core/sdi_tx_insert.sv ***
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "sdi_tx_map.svh"
module sdi_tx_insert #(
    parameter logic [31:0] VPID_PAYLOAD = 32'h0000_0000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stream from the source
    sdi_tx_if.transmitter tx,
    // Stream toward the serialiser
    output sdi_tx_pkg::word_type y_out,
    output sdi_tx_pkg::word_type c_out
);
    import sdi_tx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Word builders

    function automatic word_type anc(input logic [7:0] b);
        anc = {~(^b), ^b, b};
    endfunction

    function automatic word_type ln_word(input logic [10:0] ln, input logic hi);
        ln_word = hi ? {1'b1, 3'b000, ln[10:7], 2'b00} : {~ln[6], ln[6:0], 2'b00};
    endfunction

    function automatic logic [17:0] crc_step(input logic [17:0] c, input word_type w);
        logic [17:0] r;
        r = c;
        for (int i = 0; i < 10; i++) begin
            if (r[0] ^ w[i]) begin
                r = (r >> 1) ^ `CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        crc_step = r;
    endfunction

    function automatic word_type pkt_word(input logic [3:0] i, input logic e,
                                          input logic [3:0] last, input logic [31:0] u,
                                          input logic [8:0] cs);
        logic [1:0] k;
        logic [31:0] sh;
        k = i[1:0] + 2'b10;
        sh = u >> {k, 3'b000};
        if (i == 4'h0) begin
            pkt_word = `TRS_ZERO;
        end else if (i == 4'h1 || i == 4'h2) begin
            pkt_word = `TRS_ONES;
        end else if (i == 4'h3) begin
            pkt_word = anc(e ? `DID_EDH : `DID_VPID);
        end else if (i == 4'h4) begin
            pkt_word = anc(e ? `DBN_EDH : `SDID_VPID);
        end else if (i == 4'h5) begin
            pkt_word = anc(e ? `EDH_LEN : `VPID_LEN);
        end else if (i == last) begin
            pkt_word = {~cs[8], cs};
        end else begin
            pkt_word = anc(sh[7:0]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    tx_state_type s;
    tx_state_type n;
    logic trs;
    logic exist;
    logic hd_now;
    logic go;
    logic kind;
    logic [3:0] idx;
    logic [3:0] last;
    logic [31:0] udw;
    logic [4:0] cur;
    logic [4:0] slot0;
    word_type xyz;
    word_type wy;
    word_type wc;

    always_comb begin
        n = s;
        trs = s.yd[3] == `TRS_ONES && s.yd[2] == `TRS_ZERO && s.yd[1] == `TRS_ZERO;
        xyz = s.yd[0];
        cur = trs ? 5'h00 : s.pos;
        slot0 = s.hd ? `SLOT_HD : `SLOT_SD;
        hd_now = tx.mode == MODE_HD || tx.mode == MODE_3G;
        exist = s.yd[3] == `TRS_ZERO && s.yd[2] == `TRS_ONES && s.yd[1] == `TRS_ONES
            && s.yd[0][7:0] == `DID_VPID;
        // Both stream A inputs pass unchanged apart from inserted words
        wy = s.yd[3];
        wc = s.cd[3];
        n.yd = {s.yd[2:0], tx.video_a_y};
        n.cd = {s.cd[2:0], tx.video_a_c};
        n.pos = (cur == `POS_MAX) ? cur : cur + 5'h01;
        n.sum = s.sum + {6'h00, s.yd[3]};
        if (trs) begin
            n.eav = xyz[6];
            if (xyz[6]) begin
                n.hd = hd_now;
                n.sd = tx.mode == MODE_SD;
                n.ins_ln = tx.insert_ln;
                n.ins_edh = tx.insert_edh;
                n.ins_vpid = tx.insert_vpid;
                n.ovw = tx.overwrite_vpid;
                n.ln = tx.line_a;
                if (xyz[8] != s.fld) begin
                    n.fld = xyz[8];
                    n.edh_pend = 1'b1;
                    n.vpid_pend = 1'b1;
                end
            end else begin
                n.crc_y = '0;
                n.crc_c = '0;
                n.crc_on = hd_now && tx.insert_crc;
            end
        end

        // Line number words right after the XYZ word of the EAV
        if (s.eav && s.hd && s.ins_ln && (cur == `POS_LN0 || cur == `POS_LN1)) begin
            wy = ln_word(s.ln, cur == `POS_LN1);
            wc = wy;
        end

        // Line CRC runs from the first active word through the second line number word
        if (s.crc_on && (s.eav || trs || cur > `POS_XYZ)) begin
            n.crc_y = crc_step(s.crc_y, wy);
            n.crc_c = crc_step(s.crc_c, wc);
        end
        if (s.eav && cur == `POS_LN1) begin
            n.crc_rdy = s.crc_on;
            n.crc_on = 1'b0;
        end
        if (s.eav && s.crc_rdy && cur == `POS_CR0) begin
            wy = {~s.crc_y[8], s.crc_y[8:0]};
            wc = {~s.crc_c[8], s.crc_c[8:0]};
        end
        if (s.eav && s.crc_rdy && cur == `POS_CR1) begin
            wy = {~s.crc_y[17], s.crc_y[17:9]};
            wc = {~s.crc_c[17], s.crc_c[17:9]};
            n.crc_rdy = 1'b0;
        end

        // Packet slot on the first line of each field, and on the second line for a VPID that follows an EDH packet
        go = s.pst == PKT_SEND;
        kind = s.kind_edh;
        idx = s.idx;
        last = s.last;
        udw = s.udw;
        if (s.eav && cur == slot0 && s.pst == PKT_IDLE) begin
            n.edh_pend = 1'b0;
            if (s.sd && s.edh_pend && s.ins_edh) begin
                go = 1'b1;
                kind = 1'b1;
                last = `LAST_EDH;
                udw = {16'h0000, s.sum};
                n.sum = 16'h0000;
            end else begin
                n.vpid_pend = 1'b0;
                if (s.vpid_pend && s.ins_vpid && (!exist || s.ovw)) begin
                    go = 1'b1;
                    kind = 1'b0;
                    last = `LAST_VPID;
                    udw = VPID_PAYLOAD;
                end
            end
            idx = 4'h0;
        end
        if (go) begin
            wy = pkt_word(idx, kind, last, udw, s.cs);
            n.kind_edh = kind;
            n.last = last;
            n.udw = udw;
            n.idx = idx + 4'h1;
            n.cs = ((idx == `PKT_CS0) ? 9'h000 : s.cs) + wy[8:0];
            n.pst = (idx == last) ? PKT_IDLE : PKT_SEND;
        end

        n.y_out = wy;
        n.c_out = wc;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign y_out = s.y_out;
    assign c_out = s.c_out;
endmodule

// *** core/sdi_tx_source.sv ***
`timescale 1ns/10ps
`include "sdi_tx_map.svh"
module sdi_tx_source #(
    parameter logic [11:0] ACT_WORDS = 12'd64,
    parameter logic [11:0] HBLK_WORDS = 12'd32,
    parameter logic [10:0] LINES = 11'd8,
    parameter logic [10:0] VBLK_LINES = 11'd2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Stream toward the transmitter
    sdi_tx_if.source tx
);
    import sdi_tx_pkg::*;

    function automatic word_type xyz_word(input logic f, input logic v, input logic h);
        xyz_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register access and pattern generation

    src_state_type s;
    src_state_type n;
    logic mapped;
    logic v;
    logic h;

    always_comb begin
        n = s;
        mapped = paddr == `REG_CTRL || paddr == `REG_STAT;
        if (psel && !penable) begin
            if (paddr == `REG_CTRL) begin
                n.rdata = s.ctrl;
            end else if (paddr == `REG_STAT) begin
                n.rdata = {15'h0000, s.fld, 5'h00, s.line};
            end else begin
                n.rdata = 32'h0000_0000;
            end
        end
        if (psel && penable && pwrite && paddr == `REG_CTRL) begin
            n.ctrl = pwdata & `CTRL_MASK;
        end

        v = s.line <= VBLK_LINES;
        h = s.ph == PH_EAV;
        n.wcnt = s.wcnt + 12'h001;
        n.y = `BLANK_Y;
        n.c = `BLANK_C;
        if (!s.ctrl[`CTRL_RUN]) begin
            n.ph = PH_EAV;
            n.wcnt = 12'h000;
        end else begin
            case (s.ph)
                PH_EAV, PH_SAV: begin
                    if (s.wcnt == 12'h000) begin
                        n.y = `TRS_ONES;
                    end else if (s.wcnt == 12'h003) begin
                        n.y = xyz_word(s.fld, v, h);
                    end else begin
                        n.y = `TRS_ZERO;
                    end
                    n.c = n.y;
                    if (h && s.wcnt == 12'h000) begin
                        // Line number changes with the first EAV word
                        if (s.line >= LINES) begin
                            n.line = 11'd1;
                            n.fld = ~s.fld;
                        end else begin
                            n.line = s.line + 11'd1;
                        end
                    end
                    if (s.wcnt == 12'h003) begin
                        n.ph = h ? PH_HBLK : PH_ACT;
                        n.wcnt = 12'h000;
                    end
                end
                PH_HBLK: begin
                    if (s.wcnt == HBLK_WORDS - 12'h001) begin
                        n.ph = PH_SAV;
                        n.wcnt = 12'h000;
                    end
                end
                default: begin
                    n.y = {2'b01, s.wcnt[7:0]};
                    if (s.wcnt == ACT_WORDS - 12'h001) begin
                        n.ph = PH_EAV;
                        n.wcnt = 12'h000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{ctrl: `CTRL_RST, ph: PH_EAV, default: '0};
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign tx.video_a_y = s.y;
    assign tx.video_a_c = s.c;
    assign tx.mode = mode_type'(s.ctrl[`CTRL_MODE +: 2]);
    assign tx.high_rate_level_select = s.ctrl[`CTRL_LVLB];
    assign tx.insert_crc = s.ctrl[`CTRL_CRC];
    assign tx.insert_ln = s.ctrl[`CTRL_LN];
    assign tx.insert_edh = s.ctrl[`CTRL_EDH];
    assign tx.insert_vpid = s.ctrl[`CTRL_VPID];
    assign tx.overwrite_vpid = s.ctrl[`CTRL_OVW];
    assign tx.line_a = s.line;
    assign tx.line_b = s.line;
endmodule

// *** tb/sdi_tx_properties.sv ***
`timescale 1ns/10ps
`include "sdi_tx_map.svh"
module sdi_tx_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link from the source
    input wire sdi_tx_pkg::word_type video_a_y,
    input wire sdi_tx_pkg::word_type video_a_c,
    input wire sdi_tx_pkg::mode_type mode,
    input wire logic high_rate_level_select,
    input wire logic insert_crc,
    input wire logic insert_ln,
    input wire logic insert_edh,
    input wire logic insert_vpid,
    input wire logic overwrite_vpid,
    input wire logic [10:0] line_a,
    input wire logic [10:0] line_b,
    // Transmitter output
    input wire sdi_tx_pkg::word_type y_out,
    input wire sdi_tx_pkg::word_type c_out
);
    import sdi_tx_pkg::*;
    logic [7:0] age_q;
    logic [6:0] cfg_q;
    logic [6:0] cfg;
    logic settled;
    logic hd3g;
    assign cfg = {mode, insert_crc, insert_ln, insert_edh, insert_vpid, overwrite_vpid};
    assign settled = age_q > 8'h8c;
    assign hd3g = mode == MODE_HD || mode == MODE_3G;
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the configuration last moved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_q <= 8'h00;
            cfg_q <= 7'h00;
        end else begin
            cfg_q <= cfg;
            if (cfg != cfg_q) begin
                age_q <= 8'h00;
            end else if (age_q != 8'hff) begin
                age_q <= age_q + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence eav_word;
        settled && $past(y_out, 3) == `TRS_ONES && $past(y_out, 2) == `TRS_ZERO
            && $past(y_out, 1) == `TRS_ZERO && y_out[6];
    endsequence
    sequence pkt_did;
        settled && $past(y_out, 3) == `TRS_ZERO && $past(y_out, 2) == `TRS_ONES
            && $past(y_out, 1) == `TRS_ONES;
    endsequence
    chk_luma_pass: assert property (settled && $past(video_a_y[9:8], 5) == 2'h1
        |-> y_out == $past(video_a_y, 5)) else $error("luma word not passed");
    chk_chroma_pass: assert property (settled && mode != MODE_SD
        && $past(video_a_c[9:8], 5) == 2'h1 |-> c_out == $past(video_a_c, 5))
        else $error("chroma word not passed");
    chk_line_words: assert property (eav_word ##0 (hd3g && insert_ln)
        |=> y_out == {~line_a[6], line_a[6:0], 2'h0} ##1 y_out == {1'h1, 3'h0, line_a[10:7], 2'h0})
        else $error("line number words wrong");
    chk_chroma_lines: assert property (eav_word ##0 (hd3g && insert_ln)
        |=> (c_out == y_out) [*2]) else $error("chroma line number differs");
    chk_hd_plain: assert property (eav_word
        ##0 (mode == MODE_HD && !insert_ln && !insert_crc)
        |=> (y_out == $past(video_a_y, 5)) [*4]) else $error("words altered with inserts off");
    chk_sd_ignores: assert property (eav_word
        ##0 (mode == MODE_SD && !insert_edh && !insert_vpid)
        |=> (y_out == $past(video_a_y, 5)) [*4]) else $error("sd words altered");
    chk_edh_sd_only: assert property (pkt_did ##0 y_out[7:0] == `DID_EDH
        |-> mode == MODE_SD && insert_edh) else $error("error packet not allowed");
    chk_vpid_enabled: assert property (pkt_did ##0 y_out[7:0] == `DID_VPID
        |-> insert_vpid) else $error("identifier packet not allowed");
    cover property (eav_word ##0 insert_ln);
    cover property (pkt_did ##0 y_out[7:0] == `DID_EDH);
    cover property (pkt_did ##0 y_out[7:0] == `DID_VPID);
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`include "sdi_tx_map.svh"
`define CHECK(g, e) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
end
module testbench;
    import sdi_tx_pkg::*;
    typedef struct {logic [31:0] ctrl; logic ln; logic crc; logic edh; logic vpid;} row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, armed, ln_on, crc_on;
    logic fld_q, first, eav, hd3g;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [17:0] crc [2];
    logic run [2];
    logic [4:0] pos;
    logic [10:0] ln;
    word_type y_out, c_out, w, ex;
    word_type hist [3];
    word_type dly [2][5];
    int errors, tests_run, n_fld, n_edh, n_vpid;
    row_type rows [8] = '{'{32'h0000_0003, 1, 1, 0, 0}, '{32'h0000_0000, 0, 0, 0, 0},
        '{32'h0000_0107, 0, 0, 1, 0}, '{32'h0000_0219, 0, 1, 0, 1}, '{32'h0000_002c, 0, 0, 0, 1},
        '{32'h0000_0303, 0, 0, 0, 0}, '{32'h0000_0103, 0, 0, 0, 0}, '{32'h0000_0233, 1, 1, 0, 0}};
    sdi_tx_if tx_bus();
    assign ln = tx_bus.line_a;
    assign hd3g = tx_bus.mode == MODE_HD || tx_bus.mode == MODE_3G;
    sdi_tx_source #(.ACT_WORDS(12'h020), .HBLK_WORDS(12'h018)) u_sdi_tx_source (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx(tx_bus.source));
    sdi_tx_insert #(.VPID_PAYLOAD(32'h5a3c_0f96)) u_sdi_tx_insert (.pclk(pclk), .presetn(presetn),
        .tx(tx_bus.transmitter), .y_out(y_out), .c_out(c_out));
    sdi_tx_properties u_sdi_tx_properties (.pclk(pclk), .presetn(presetn),
        .video_a_y(tx_bus.video_a_y), .video_a_c(tx_bus.video_a_c), .mode(tx_bus.mode),
        .high_rate_level_select(tx_bus.high_rate_level_select), .insert_crc(tx_bus.insert_crc),
        .insert_ln(tx_bus.insert_ln), .insert_edh(tx_bus.insert_edh),
        .insert_vpid(tx_bus.insert_vpid), .overwrite_vpid(tx_bus.overwrite_vpid),
        .line_a(tx_bus.line_a), .line_b(tx_bus.line_b), .y_out(y_out), .c_out(c_out));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [17:0] crc_step(input logic [17:0] c, input word_type d);
        logic [17:0] r;
        r = c;
        for (int i = 0; i < 10; i++) r = (r >> 1) ^ ((r[0] ^ d[i]) ? `CRC_POLY : 18'h0);
        return r;
    endfunction
    task automatic report_and_stop;
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_slot;
        int n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(eav === 1'h1 && pos == 5'h14) && n < 400);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Output monitor: framing, packet counts, line words and line CRC
    always @(posedge pclk) begin
        if (hist[2] == `TRS_ONES && hist[1] == `TRS_ZERO && hist[0] == `TRS_ZERO) begin
            pos = 5'h3;
            eav = y_out[6];
            if (eav) begin
                first = y_out[8] !== fld_q;
                fld_q = y_out[8];
                if (armed && first) n_fld++;
            end
        end else if (pos != 5'h1f) begin
            pos++;
        end
        if (armed && hist[2] == `TRS_ZERO && hist[1] == `TRS_ONES && hist[0] == `TRS_ONES) begin
            n_edh += int'(y_out[7:0] == `DID_EDH);
            n_vpid += int'(y_out[7:0] == `DID_VPID);
        end
        for (int s = 0; s < 2; s++) begin
            w = s ? c_out : y_out;
            ex = dly[s][4];
            if (pos == 5'h3 && !eav) begin
                crc[s] = 18'h0;
                run[s] = 1'h1;
            end else if (run[s]) begin
                crc[s] = crc_step(crc[s], w);
                run[s] = !(eav && pos == 5'h5);
            end
            if (armed && eav && pos >= 5'h4 && pos <= 5'h7) begin
                if (pos < 5'h6 && ln_on) begin
                    ex = pos == 5'h4 ? {~ln[6], ln[6:0], 2'h0} : {1'h1, 3'h0, ln[10:7], 2'h0};
                    `CHECK(w, ex)
                end else if (pos > 5'h5 && crc_on) begin
                    ex = pos == 5'h6 ? {~crc[s][8], crc[s][8:0]} : {~crc[s][17], crc[s][17:9]};
                    `CHECK(w, ex)
                end else if (!(first && !hd3g)) begin
                    `CHECK(w, ex)
                end
            end
            for (int i = 4; i > 0; i--) dly[s][i] = dly[s][i - 1];
            dly[s][0] = s ? tx_bus.video_a_c : tx_bus.video_a_y;
        end
        hist[2] = hist[1];
        hist[1] = hist[0];
        hist[0] = y_out;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #2500000;
        errors++;
        report_and_stop();
    end
    initial begin
        errors = 0;
        tests_run = 0;
        armed = 1'h0;
        fld_q = 1'h0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        `CHECK(y_out, 10'h000)
        `CHECK(tx_bus.insert_crc, 1'h0)
        presetn <= 1'h1;
        apb(1'h0, `REG_CTRL, 32'h0);
        `CHECK(rd, `CTRL_RST)
        apb(1'h1, `REG_CTRL, 32'hffff_ffff);
        apb(1'h0, `REG_CTRL, 32'h0);
        `CHECK(rd, `CTRL_MASK)
        apb(1'h1, 12'h008, 32'h1);
        `CHECK(err, 1'h1)
        apb(1'h0, 12'h008, 32'h0);
        `CHECK(rd, 32'h0)
        foreach (rows[i]) begin
            apb(1'h1, `REG_CTRL, rows[i].ctrl | 32'h0001_0000);
            repeat (2) @(posedge pclk);
            `CHECK(tx_bus.mode, mode_type'(rows[i].ctrl[9:8]))
            `CHECK(tx_bus.high_rate_level_select, rows[i].ctrl[5])
            `CHECK(tx_bus.overwrite_vpid, rows[i].ctrl[4])
            ln_on = rows[i].ln;
            crc_on = rows[i].crc;
            repeat (600) @(posedge pclk);
            wait_slot();
            n_fld = 0;
            n_edh = 0;
            n_vpid = 0;
            armed = 1'h1;
            repeat (1100) @(posedge pclk);
            wait_slot();
            armed = 1'h0;
            `CHECK(n_fld > 1, 1'h1)
            `CHECK(n_edh, rows[i].edh ? n_fld : 0)
            `CHECK(n_vpid, rows[i].vpid ? n_fld : 0)
        end
        // Reset in mid-run: outputs clear, control returns to reset, idle words follow
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        `CHECK(y_out, 10'h000)
        `CHECK(c_out, 10'h000)
        `CHECK(tx_bus.insert_ln, 1'h0)
        presetn <= 1'h1;
        apb(1'h0, `REG_CTRL, 32'h0);
        `CHECK(rd, `CTRL_RST)
        repeat (4) @(posedge pclk);
        `CHECK(y_out, `BLANK_Y)
        `CHECK(c_out, `BLANK_C)
        report_and_stop();
    end
endmodule
